// ### host_irq_status.sv
// Purpose: Sticky event flags, per-source enables, FIFO level compare
// Assumes: Event inputs come from logic on hclk, no synchroniser needed
// Notes:   Read data is taken from next-state values, so a read right
//          after a write already shows the written word

`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Transmitter error sets sticky bit 13
// R2: Write into full tx data FIFO sets bit 10
// R3: Tx free blocks above level set bit 9
// R4: Tx status FIFO full sets bit 8
// R5: Tx status used above level sets bit 7
// R6: Dropped receive frame sets bit 6
// R7: Rx status FIFO full sets bit 4
// R8: Rx status used above level sets bit 3
// R9: Pin events latch into bits 2:0
// R10: Enable one admits source, zero masks it
// R11: Flags update regardless of enable state
// R12: Enable bits writable only at listed positions
// R13: Byte order register reads fixed test word
// R14: Threshold fields writable, bits 15:8 reserved
// R15: Interrupt high while flag and enable both set
// R16: Host clears flags by writing ones
module host_irq_status
    import host_irq_pkg::*;
#(
    parameter int LVL_W = 8,
    parameter int PIN_N = 3
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Transmit side sources
    input wire logic tx_error_evt,
    input wire logic tx_data_wr_evt,
    input wire logic tx_data_full,
    input wire logic [LVL_W-1:0] tx_data_free_blk,
    input wire logic tx_status_full,
    input wire logic [LVL_W-1:0] tx_status_used,
    // Receive side sources
    input wire logic rx_drop_evt,
    input wire logic rx_status_full,
    input wire logic [LVL_W-1:0] rx_status_used,
    // Qualified pin events
    input wire logic [PIN_N-1:0] pin_evt,
    // Host interrupt line
    output logic irq
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Field layout is fixed at eight bits and three pins
    if (LVL_W != 8) begin : g_bad_lvl
        $error("LVL_W must be 8");
    end
    if (PIN_N != 3) begin : g_bad_pin
        $error("PIN_N must be 3");
    end

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Word address match inside the window
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a[7:2] == off[7:2]);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic wr_pend_q; // Write data phase pending
    logic [7:0] wr_addr_q; // Latched write address
    logic [31:0] sts_q; // Sticky flags
    logic [31:0] sts_d;
    logic [31:0] en_q; // Source enables
    logic [31:0] en_d;
    logic [31:0] lvl_q; // Threshold fields
    logic [31:0] lvl_d;
    logic [31:0] rdata_q; // Read data phase value
    logic rdy_q; // Ready out, always one
    logic resp_q; // Response out, always OKAY
    logic irq_q; // Interrupt line

    // ------------------------------------------------------------
    // Address phase decode
    // ------------------------------------------------------------
    // Only whole-word transfers act; others finish OKAY and do nothing
    wire logic ap_take;
    wire logic ap_wr;
    wire logic ap_rd;
    assign ap_take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
    assign ap_wr = ap_take & hwrite;
    assign ap_rd = ap_take & ~hwrite;

    // ------------------------------------------------------------
    // Data phase write strobes
    // ------------------------------------------------------------
    wire logic wr_sts;
    wire logic wr_en;
    wire logic wr_lvl;
    assign wr_sts = wr_pend_q & hit(wr_addr_q, STS_OFF);
    assign wr_en = wr_pend_q & hit(wr_addr_q, EN_OFF);
    assign wr_lvl = wr_pend_q & hit(wr_addr_q, LVL_OFF);

    // ------------------------------------------------------------
    // Level comparators
    // ------------------------------------------------------------
    wire logic space_hit;
    wire logic tslvl_hit;
    wire logic rslvl_hit;
    // R3: free blocks above level
    assign space_hit = tx_data_free_blk > lvl_q[TDA_LSB +: 8];
    // R5: tx status used above level
    assign tslvl_hit = tx_status_used > lvl_q[TSL_LSB +: 8];
    // R8: rx status used above level
    assign rslvl_hit = rx_status_used > lvl_q[RSL_LSB +: 8];

    // ------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------
    // Full and level conditions set again every cycle they hold,
    // so clearing them while the cause stays has no lasting effect
    wire logic ovr_evt;
    wire logic [31:0] sts_set;
    // R2: write attempt while full
    assign ovr_evt = tx_data_wr_evt & tx_data_full;
    // R1: error event
    // R4: tx status full
    // R6: dropped frame
    // R7: rx status full
    // R9: pin event bits
    assign sts_set = (32'(tx_error_evt) << TXE_BIT)
                   | (32'(ovr_evt) << OVR_BIT)
                   | (32'(space_hit) << SPACE_BIT)
                   | (32'(tx_status_full) << TSFULL_BIT)
                   | (32'(tslvl_hit) << TSLVL_BIT)
                   | (32'(rx_drop_evt) << DROP_BIT)
                   | (32'(rx_status_full) << RSFULL_BIT)
                   | (32'(rslvl_hit) << RSLVL_BIT)
                   | (32'(pin_evt) << PIN_LSB);

    // ------------------------------------------------------------
    // Next-state values
    // ------------------------------------------------------------
    wire logic [31:0] sts_clr;
    // R16: ones in the written word clear
    assign sts_clr = wr_sts ? hwdata : 32'h0000_0000;
    // R11: set ignores enables; set wins over clear
    assign sts_d = ((sts_q & ~sts_clr) | sts_set) & STS_IMPL;
    // R12: only listed enable bits store
    assign en_d = wr_en ? (hwdata & EN_RW_MASK) : en_q;
    // R14: reserved threshold bits stay zero
    assign lvl_d = wr_lvl ? (hwdata & LVL_RW_MASK) : lvl_q;

    // ------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------
    // Unmapped words read as zero
    wire logic [31:0] rd_val;
    // R13: fixed test word
    assign rd_val = hit(haddr[7:0], STS_OFF) ? sts_d :
                    hit(haddr[7:0], EN_OFF) ? en_d :
                    hit(haddr[7:0], TEST_OFF) ? TEST_VAL :
                    hit(haddr[7:0], LVL_OFF) ? lvl_d :
                    32'h0000_0000;

    // ------------------------------------------------------------
    // Bus phase tracking
    // ------------------------------------------------------------
    // Write address kept for the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= ap_wr;
            wr_addr_q <= haddr[7:0];
        end
    end

    // Read data held for one data phase, zero otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (hready) begin
            rdata_q <= ap_rd ? rd_val : 32'h0000_0000;
        end
    end

    // Zero wait states; never any error response
    // Kept as flops so every top output leaves a register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdy_q <= 1'b1;
            resp_q <= 1'b0;
        end else begin
            rdy_q <= 1'b1;
            resp_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Flags, enables and thresholds
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sts_q <= STS_RST;
            en_q <= EN_RST;
            lvl_q <= LVL_RST;
        end else begin
            sts_q <= sts_d;
            en_q <= en_d;
            lvl_q <= lvl_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt line
    // ------------------------------------------------------------
    // Built from next values so the line tracks the flags exactly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            // R10: enable gates each source
            // R15: any enabled flag raises the line
            irq_q <= |(sts_d & en_d);
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout = rdy_q;
    assign hrdata = rdata_q;
    assign hresp = resp_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_irq_track;
        irq == |(sts_q & en_q);
    endproperty
    a_irq_track: assert property (p_irq_track) // R15
        else $error("irq does not match enabled flags");

    property p_irq_mask;
        (sts_q != 32'h0 && en_q == 32'h0) |-> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) // R10
        else $error("masked flag raised irq");

    property p_txe;
        tx_error_evt |=> sts_q[TXE_BIT];
    endproperty
    a_txe: assert property (p_txe) // R1
        else $error("tx error flag not set");

    property p_ovr;
        tx_data_wr_evt && tx_data_full |=> sts_q[OVR_BIT];
    endproperty
    a_ovr: assert property (p_ovr) // R2
        else $error("overrun flag not set");

    property p_ovr_quiet;
        !sts_q[OVR_BIT] && !(tx_data_wr_evt && tx_data_full)
            |=> !sts_q[OVR_BIT];
    endproperty
    a_ovr_quiet: assert property (p_ovr_quiet) // R2
        else $error("overrun flag set without cause");

    property p_space;
        tx_data_free_blk > lvl_q[TDA_LSB +: 8] |=> sts_q[SPACE_BIT];
    endproperty
    a_space: assert property (p_space) // R3
        else $error("space flag not set");

    property p_space_quiet;
        !sts_q[SPACE_BIT] && tx_data_free_blk <= lvl_q[TDA_LSB +: 8]
            |=> !sts_q[SPACE_BIT];
    endproperty
    a_space_quiet: assert property (p_space_quiet) // R3
        else $error("space flag set at or below level");

    property p_tsfull;
        tx_status_full |=> sts_q[TSFULL_BIT];
    endproperty
    a_tsfull: assert property (p_tsfull) // R4
        else $error("tx status full flag not set");

    property p_tslvl;
        tx_status_used > lvl_q[TSL_LSB +: 8] |=> sts_q[TSLVL_BIT];
    endproperty
    a_tslvl: assert property (p_tslvl) // R5
        else $error("tx status level flag not set");

    property p_drop;
        rx_drop_evt |=> sts_q[DROP_BIT];
    endproperty
    a_drop: assert property (p_drop) // R6
        else $error("dropped frame flag not set");

    property p_rsfull;
        rx_status_full |=> sts_q[RSFULL_BIT];
    endproperty
    a_rsfull: assert property (p_rsfull) // R7
        else $error("rx status full flag not set");

    property p_rslvl;
        rx_status_used > lvl_q[RSL_LSB +: 8] |=> sts_q[RSLVL_BIT];
    endproperty
    a_rslvl: assert property (p_rslvl) // R8
        else $error("rx status level flag not set");

    property p_pin;
        (pin_evt != 3'h0) |=>
            ((sts_q[2:0] & $past(pin_evt)) == $past(pin_evt));
    endproperty
    a_pin: assert property (p_pin) // R9
        else $error("pin event not latched");

    property p_noen;
        tx_error_evt && !en_q[TXE_BIT] |=> sts_q[TXE_BIT];
    endproperty
    a_noen: assert property (p_noen) // R11
        else $error("flag blocked by disabled source");

    property p_en_wr;
        wr_en |=> en_q == ($past(hwdata) & EN_RW_MASK);
    endproperty
    a_en_wr: assert property (p_en_wr) // R12
        else $error("enable write stored wrong bits");

    property p_test;
        ap_rd && hit(haddr[7:0], TEST_OFF) |=> hrdata == TEST_VAL;
    endproperty
    a_test: assert property (p_test) // R13
        else $error("test word read wrong");

    property p_lvl_wr;
        wr_lvl |=> lvl_q == ($past(hwdata) & LVL_RW_MASK);
    endproperty
    a_lvl_wr: assert property (p_lvl_wr) // R14
        else $error("threshold write stored wrong bits");

    property p_clr;
        wr_sts && hwdata[TXE_BIT] && !tx_error_evt |=> !sts_q[TXE_BIT];
    endproperty
    a_clr: assert property (p_clr) // R16
        else $error("write one did not clear flag");

    property p_keep;
        wr_sts && !hwdata[TXE_BIT] && sts_q[TXE_BIT]
            |=> sts_q[TXE_BIT];
    endproperty
    a_keep: assert property (p_keep) // R16
        else $error("write zero cleared flag");

endmodule

`default_nettype wire

// ### host_irq_pkg.sv
// Purpose: Shared constants of the host interrupt status and enable block
// Assumes: 32-bit AHB-Lite data, one aligned word per register
// Notes:   Offsets are byte addresses inside the block's window

package host_irq_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] STS_OFF = 8'h58;
    localparam logic [7:0] EN_OFF = 8'h5c;
    localparam logic [7:0] TEST_OFF = 8'h64;
    localparam logic [7:0] LVL_OFF = 8'h68;

    // ------------------------------------------------------------
    // Status and enable bit positions
    // ------------------------------------------------------------
    localparam int TXE_BIT = 13;
    localparam int OVR_BIT = 10;
    localparam int SPACE_BIT = 9;
    localparam int TSFULL_BIT = 8;
    localparam int TSLVL_BIT = 7;
    localparam int DROP_BIT = 6;
    localparam int RSFULL_BIT = 4;
    localparam int RSLVL_BIT = 3;
    localparam int PIN_LSB = 0;

    // ------------------------------------------------------------
    // Threshold field positions
    // ------------------------------------------------------------
    localparam int TDA_LSB = 24;
    localparam int TSL_LSB = 16;
    localparam int RSL_LSB = 0;

    // ------------------------------------------------------------
    // Masks and values after reset
    // ------------------------------------------------------------
    localparam logic [31:0] STS_IMPL = 32'h0000_27df;
    localparam logic [31:0] EN_RW_MASK = 32'h83bf_e7df;
    localparam logic [31:0] LVL_RW_MASK = 32'hffff_00ff;
    localparam logic [31:0] LVL_RST = 32'h4800_0000;
    localparam logic [31:0] STS_RST = 32'h0000_0000;
    localparam logic [31:0] EN_RST = 32'h0000_0000;
    localparam logic [31:0] TEST_VAL = 32'h8765_4321;

    // ------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------
    localparam logic [2:0] HSIZE_WORD = 3'b010;

endpackage

// ### host_bus_model.sv
// Purpose: AHB-Lite host model driving the interrupt block's registers
// Assumes: Single slave, hready fed back from the slave's hreadyout
// Notes:   Tasks are entered just after a rising edge of hclk
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    // Clock
    input wire logic hclk,
    // Bus outputs
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Bus inputs
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    // Idle bus from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // One single word transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic clear_flags(input logic [31:0] m);
        logic [31:0] unused;
        xfer(8'h58, 1'b1, m, unused);
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench of the host interrupt status block
// Assumes: Zero wait-state slave; thresholds all set to 10h for events
// Notes:   Level sources sit at 10h when idle to probe the strict compare
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // Clock, reset and counters
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    int bad_count = 0;
    int n_checks = 0;
    // Bus wires
    wire logic hsel, hwrite, hreadyout, hresp, irq;
    wire logic [31:0] haddr, hwdata, hrdata;
    wire logic [1:0] htrans;
    wire logic [2:0] hsize;
    // Event sources, idle at time zero
    logic tx_error_evt = 0, tx_data_wr_evt = 0, tx_data_full = 0;
    logic tx_status_full = 0, rx_drop_evt = 0, rx_status_full = 0;
    logic [7:0] tx_data_free_blk = 0, tx_status_used = 0, rx_status_used = 0;
    logic [2:0] pin_evt = 0;
    logic [31:0] rd;

    always #5 hclk = ~hclk;

    host_bus_model host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata));

    host_irq_status dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .tx_error_evt(tx_error_evt), .tx_data_wr_evt(tx_data_wr_evt),
        .tx_data_full(tx_data_full), .tx_data_free_blk(tx_data_free_blk),
        .tx_status_full(tx_status_full), .tx_status_used(tx_status_used),
        .rx_drop_evt(rx_drop_evt), .rx_status_full(rx_status_full),
        .rx_status_used(rx_status_used), .pin_evt(pin_evt), .irq(irq));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(a, 1'b0, 32'h0, rd);
        chk(rd, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(a, 1'b1, d, rd);
    endtask

    // Drive one source by its status bit; off leaves levels at the 10h boundary
    task automatic set_src(input int b, input logic v);
        case (b)
            13: tx_error_evt <= v;
            10: begin
                tx_data_wr_evt <= 1'b1;
                tx_data_full <= v;
            end
            9: tx_data_free_blk <= v ? 8'h11 : 8'h10;
            8: tx_status_full <= v;
            7: tx_status_used <= v ? 8'h11 : 8'h10;
            6: rx_drop_evt <= v;
            4: rx_status_full <= v;
            3: rx_status_used <= v ? 8'h11 : 8'h10;
            default: pin_evt[b] <= v;
        endcase
    endtask

    // Reset values, read-only and unmapped places
    task automatic t_reset;
        chk({30'h0, hresp, irq}, 32'h0);
        rd_chk(8'h58, 32'h0);
        rd_chk(8'h5c, 32'h0);
        wr(8'h64, 32'h0);
        rd_chk(8'h64, 32'h8765_4321);
        rd_chk(8'h68, 32'h4800_0000);
        wr(8'h60, 32'hffff_ffff);
        rd_chk(8'h60, 32'h0);
        $display("test reset done");
    endtask

    // Writable positions of enable and threshold words
    task automatic t_fields;
        wr(8'h5c, 32'hffff_ffff);
        rd_chk(8'h5c, 32'h83bf_e7df);
        wr(8'h68, 32'hffff_ffff);
        rd_chk(8'h68, 32'hffff_00ff);
        wr(8'h68, 32'h1010_0010);
        rd_chk(8'h68, 32'h1010_0010);
        $display("test fields done");
    endtask

    // Every source sets its flag and the line, then clears by write-one
    task automatic t_events;
        int bits[11] = '{13, 10, 9, 8, 7, 6, 4, 3, 2, 1, 0};
        foreach (bits[i]) begin
            set_src(bits[i], 1'b0);
            @(posedge hclk);
            rd_chk(8'h58, 32'h0);
            set_src(bits[i], 1'b1);
            @(posedge hclk);
            set_src(bits[i], 1'b0);
            @(posedge hclk);
            rd_chk(8'h58, 32'h1 << bits[i]);
            chk({31'h0, irq}, 32'h1);
            host.clear_flags(32'h1 << bits[i]);
            rd_chk(8'h58, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        $display("test events done");
    endtask

    // Masked flags still latch; enabling raises the line; partial clear
    task automatic t_mask;
        wr(8'h5c, 32'h0);
        set_src(6, 1'b1);
        set_src(13, 1'b1);
        @(posedge hclk);
        set_src(6, 1'b0);
        set_src(13, 1'b0);
        @(posedge hclk);
        rd_chk(8'h58, 32'h2040);
        chk({31'h0, irq}, 32'h0);
        wr(8'h5c, 32'h40);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        host.clear_flags(32'h40);
        rd_chk(8'h58, 32'h2000);
        chk({31'h0, irq}, 32'h0);
        $display("test mask done");
    endtask

    // Reset in mid-run: registers back to defaults, level flags re-arm
    task automatic t_rerun;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({30'h0, hresp, irq}, 32'h0);
        chk(hrdata, 32'h0);
        rd_chk(8'h5c, 32'h0);
        rd_chk(8'h68, 32'h4800_0000);
        rd_chk(8'h58, 32'h0000_0088);
        $display("test rerun done");
    endtask

    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog, far beyond the roughly 180 cycles of the tests
    initial begin
        #200000;
        bad_count++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_fields();
        t_events();
        t_mask();
        t_rerun();
        final_report();
    end
endmodule
`default_nettype wire
